// ===== hw/isd_defs.vh
`ifndef ISD_DEFS_VH
`define ISD_DEFS_VH
// descriptor word three field positions (bit numbers within the 64-bit word)
`define ISD_SSM_LO 0
`define ISD_SSM_HI 7
`define ISD_SLOT0_LO 8
`define ISD_SLOT0_HI 10
`define ISD_CSM_LO 32
`define ISD_CSM_HI 39
`define ISD_CERR_LO 55
`define ISD_CERR_HI 56
`define ISD_TOGGLE 57
`define ISD_PHASE 59
`define ISD_XERR 60
`define ISD_BABBLE 61
`define ISD_HALT 62
`define ISD_ACTIVE 63
// status slot bit meanings
`define ISD_ST_XERR 0
`define ISD_ST_BABBLE 1
`define ISD_ST_UNDER 2
// frame number field in descriptor word one
`define ISD_FRM_LO 3
`define ISD_FRM_HI 7
// outcome codes from the transaction engine
`define ISD_RES_ACK 3'h0
`define ISD_RES_NAK 3'h1
`define ISD_RES_STALL 3'h2
`define ISD_RES_XERR 3'h3
`define ISD_RES_BABBLE 3'h4
`define ISD_RES_UNDER 3'h5
`define ISD_CERR_ZERO 2'h0
// start-split microframes that an IN descriptor may use, and the full mask for OUT
`define ISD_IN_SS_MASK 8'h0F
`define ISD_ALL_MF_MASK 8'hFF
`define ISD_MF_COUNT 8
`endif

// ===== hw/isd_slot_file.v
`timescale 1ns/1ps
`include "isd_defs.vh"
// eight three-bit outcome slots, one per microframe, with summary or-reduction
module isd_slot_file (
	input wire clk,
	input wire reset,
	input wire clear_all,
	input wire wr_en,
	input wire [2:0] wr_idx,
	input wire [2:0] wr_val,
	output wire [23:0] slots,
	output wire any_xerr,
	output wire any_babble
);
	reg [2:0] slot_q [0:7];
	integer i;

	// slots are written only by hardware; clear_all starts a fresh descriptor
	always @(posedge clk) begin
		if (reset || clear_all) begin
			for (i = 0; i < `ISD_MF_COUNT; i = i + 1) begin
				slot_q[i] <= 3'h0;
			end
		end else if (wr_en) begin
			slot_q[wr_idx] <= wr_val;
		end
	end

	genvar g;
	generate
		for (g = 0; g < 8; g = g + 1) begin : g_pack
			assign slots[3*g+2:3*g] = slot_q[g];
		end
	endgenerate

	// summaries follow slot bits across all microframes
	assign any_xerr = |{slot_q[0][0], slot_q[1][0], slot_q[2][0], slot_q[3][0],
		slot_q[4][0], slot_q[5][0], slot_q[6][0], slot_q[7][0]};
	assign any_babble = |{slot_q[0][1], slot_q[1][1], slot_q[2][1], slot_q[3][1],
		slot_q[4][1], slot_q[5][1], slot_q[6][1], slot_q[7][1]};
endmodule // isd_slot_file

// ===== hw/isd_interrupt_split.v
`timescale 1ns/1ps
`include "isd_defs.vh"
module isd_interrupt_split (
	input wire clk,
	input wire reset,
	// software load of a fresh descriptor
	input wire load,
	input wire [63:0] load_word_three,
	input wire [7:0] load_word_one,
	input wire load_valid,
	input wire dir_in,
	// scheduler side
	input wire [2:0] microframe,
	input wire [4:0] bus_frame,
	input wire mf_tick,
	output wire issue_req,
	output wire issue_complete,
	// transaction engine result
	input wire result_valid,
	input wire [2:0] result_code,
	// descriptor image as seen by software
	output wire [63:0] descriptor_word_three,
	output reg done_pulse
);
	reg active_q;
	reg halt_q;
	reg phase_q;
	reg toggle_q;
	reg [1:0] cerr_q;
	reg [7:0] ssm_q;
	reg [7:0] csm_q;
	reg [4:0] frame_q;
	reg dir_in_q;
	reg pend_q;
	reg [2:0] pend_mf_q;
	wire [23:0] slots;
	// summary flags come straight from the slot file
	wire any_xerr;
	wire any_babble;
	wire frame_ok;
	wire ss_hit;
	wire cs_hit;
	reg slot_we;
	reg [2:0] slot_val;
	wire [7:0] ssm_left;
	wire [7:0] csm_left;
	wire [8:0] flag_bits;

	// one-hot bit for a microframe index
	function [7:0] mf_bit;
		input [2:0] idx;
		begin
			mf_bit = 8'h01 << idx;
		end
	endfunction

	// mask with the bit of a handled microframe taken out
	function [7:0] drop_bit;
		input [7:0] mask;
		input [2:0] idx;
		begin
			drop_bit = mask & ~mf_bit(idx);
		end
	endfunction

	// OUT gates on the frame match before looking at the mask
	assign frame_ok = dir_in_q || (frame_q == bus_frame);
	assign ss_hit = active_q && !phase_q && frame_ok && ((ssm_q & mf_bit(microframe)) != 8'h00);
	// complete splits exist only for IN and only while the phase bit is set, by an answered start split or by the load
	assign cs_hit = active_q && phase_q && dir_in_q && ((csm_q & mf_bit(microframe)) != 8'h00);
	// a tick that arrives while an attempt is outstanding is dropped, not queued;
	// the scheduler simply revisits the descriptor in a later microframe
	assign issue_req = mf_tick && !pend_q && (ss_hit || cs_hit);
	// the phase bit doubles as the split kind the scheduler must send
	assign issue_complete = phase_q;

	// masks as they stand once the pending microframe is retired
	assign ssm_left = drop_bit(ssm_q, pend_mf_q);
	assign csm_left = drop_bit(csm_q, pend_mf_q);

	// map the engine result to a slot code; nak and ack leave no error bits
	// babble only means something on IN and underrun only on OUT, so the other is dropped
	always @* begin
		slot_val = 3'h0;
		slot_we = result_valid && pend_q && active_q;
		case (result_code)
			`ISD_RES_XERR: slot_val[`ISD_ST_XERR] = 1'b1;
			`ISD_RES_BABBLE: slot_val[`ISD_ST_BABBLE] = dir_in_q;
			`ISD_RES_UNDER: slot_val[`ISD_ST_UNDER] = !dir_in_q;
			default: slot_val = 3'h0;
		endcase
	end

	// slot writes stop with the active flag, which keeps a retired image frozen
	isd_slot_file u_slots (
		.clk(clk),
		.reset(reset),
		.clear_all(load),
		.wr_en(slot_we),
		.wr_idx(pend_mf_q),
		.wr_val(slot_val),
		.slots(slots),
		.any_xerr(any_xerr),
		.any_babble(any_babble)
	);

	// descriptor state; retries hold the mask bit so the attempt repeats next pass
	// priority: reset, then a software load, then a new issue, then a result;
	// issue and result cannot meet because an issue needs nothing pending
	always @(posedge clk) begin
		done_pulse <= 1'b0;
		if (reset) begin
			// outputs read zero and nothing is pending until the first load
			active_q <= 1'b0;
			halt_q <= 1'b0;
			phase_q <= 1'b0;
			toggle_q <= 1'b0;
			cerr_q <= 2'h0;
			ssm_q <= 8'h00;
			csm_q <= 8'h00;
			frame_q <= 5'h00;
			dir_in_q <= 1'b0;
			pend_q <= 1'b0;
			pend_mf_q <= 3'h0;
		end else if (load) begin
			// a load drops any attempt in flight; its late result finds nothing pending
			active_q <= load_word_three[`ISD_ACTIVE] & load_valid;
			halt_q <= 1'b0;
			phase_q <= load_word_three[`ISD_PHASE];
			toggle_q <= load_word_three[`ISD_TOGGLE];
			cerr_q <= load_word_three[`ISD_CERR_HI:`ISD_CERR_LO];
			// IN start splits beyond microframe 3 are masked off defensively
			ssm_q <= load_word_three[`ISD_SSM_HI:`ISD_SSM_LO]
				& (dir_in ? `ISD_IN_SS_MASK : `ISD_ALL_MF_MASK);
			csm_q <= dir_in ? load_word_three[`ISD_CSM_HI:`ISD_CSM_LO] : 8'h00;
			frame_q <= load_word_one[`ISD_FRM_HI:`ISD_FRM_LO];
			dir_in_q <= dir_in;
			pend_q <= 1'b0;
		end else if (issue_req) begin
			// remember the microframe so the result lands in the right slot
			pend_q <= 1'b1;
			pend_mf_q <= microframe;
		end else if (result_valid && pend_q) begin
			pend_q <= 1'b0;
			case (result_code)
				`ISD_RES_ACK: begin
					if (!phase_q) begin
						ssm_q <= ssm_left;
						if (dir_in_q) begin
							// an IN start split only opens the way for the complete split
							phase_q <= 1'b1;
						end else begin
							toggle_q <= ~toggle_q;
							if (ssm_left == 8'h00) begin
								active_q <= 1'b0;
								done_pulse <= 1'b1;
							end
						end
					end else begin
						csm_q <= 8'h00;
						toggle_q <= ~toggle_q;
						active_q <= 1'b0;
						done_pulse <= 1'b1;
					end
				end
				`ISD_RES_NAK: begin
					// a nak on a complete split gives up that microframe only
					if (phase_q) begin
						csm_q <= csm_left;
					end
				end
				`ISD_RES_STALL: begin
					// a stalled endpoint retires the descriptor; no retry is spent
					halt_q <= 1'b1;
					active_q <= 1'b0;
					done_pulse <= 1'b1;
					if (!phase_q) begin
						ssm_q <= ssm_left;
					end else begin
						csm_q <= csm_left;
					end
				end
				default: begin
					// failed attempt: spend a retry, give up when none are left
					if (cerr_q == `ISD_CERR_ZERO) begin
						halt_q <= 1'b1;
						active_q <= 1'b0;
						done_pulse <= 1'b1;
						// the last attempt still counts as handled, so its mask bit goes
						if (!phase_q) begin
							ssm_q <= ssm_left;
						end else begin
							csm_q <= csm_left;
						end
					end else begin
						// the mask bit stays, so the same microframe is tried again later
						cerr_q <= cerr_q - 2'h1;
					end
				end
			endcase
		end
	end

	// upper flag group: active, halt, babble, error, phase, reserved, toggle, retry count
	assign flag_bits = {active_q, halt_q, any_babble, any_xerr, phase_q, 1'b0,
		toggle_q, cerr_q};
	// software-visible image of descriptor word three; the reserved middle reads zero
	assign descriptor_word_three = {flag_bits, 15'h0000, csm_q, slots, ssm_q};
endmodule // isd_interrupt_split

// ===== dv/isd_dev_model.sv
`timescale 1ns/1ps
// far-side device: answers each split after one or three cycles with queued codes
module isd_dev_model (
	input wire clk,
	input wire reset,
	input wire issue_req,
	input wire slow,
	output reg result_valid = 1'b0,
	output reg [2:0] result_code = 3'h0
);
	logic [2:0] codes[$];
	int wait_n = -1;
	// the code bus is scrambled between answers so a stale code never looks valid
	always @(posedge clk) begin
		result_valid <= 1'b0;
		result_code <= ~result_code;
		if (reset)
			wait_n <= -1;
		else if (issue_req)
			wait_n <= slow ? 2 : 0;
		else if (wait_n > 0)
			wait_n <= wait_n - 1;
		else if (wait_n == 0) begin
			wait_n <= -1;
			result_valid <= 1'b1;
			result_code <= codes.size() ? codes.pop_front() : 3'h0;
		end
	end
endmodule // isd_dev_model

// ===== dv/isd_checker.sv
`timescale 1ns/1ps
module isd_checker (
	input wire clk,
	input wire reset,
	input wire load,
	input wire [2:0] microframe,
	input wire mf_tick,
	input wire issue_req,
	input wire issue_complete,
	input wire result_valid,
	input wire [2:0] result_code,
	input wire [63:0] descriptor_word_three,
	input wire done_pulse
);
	wire [63:0] w = descriptor_word_three;
	wire ok = result_valid && !load;
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	// outcome checks allow either answer latency of the far-side model
	chk_issue_tick: assert property (issue_req && !issue_complete |->
		mf_tick && w[microframe]) else $error("start split outside its mask");
	chk_done_active: assert property (done_pulse |-> !w[63] ##1 !done_pulse)
		else $error("done without active cleared");
	chk_stall_halt: assert property (issue_req ##[1:4]
		(ok && result_code == 3'h2) |=> w[62])
		else $error("stall did not halt");
	chk_babble_sum: assert property (w[61] == |(w[31:8] & 24'h492492))
		else $error("babble summary wrong");
	chk_xerr_sum: assert property (w[60] == |(w[31:8] & 24'h249249))
		else $error("error summary wrong");
	chk_slot_zero: assert property (issue_req && microframe == 3'h0 ##[1:4]
		(ok && result_code == 3'h3) |=> w[10:8] == 3'h1) else $error("slot zero wrong");
	chk_cerr_dec: assert property (issue_req ##[1:4]
		(ok && result_code == 3'h3 && w[56:55] != 2'h0) |=> w[56:55] == $past(w[56:55]) - 2'h1)
		else $error("retry count not decremented");
	chk_idle_stable: assert property (!w[63] && !load |=> $stable(w))
		else $error("image moved while inactive");
	cover property (done_pulse && w[62]);
	cover property (issue_req && issue_complete);
	cover property (done_pulse && !w[62]);
endmodule // isd_checker
bind isd_interrupt_split isd_checker i_isd_checker (.*);

// ===== dv/isd_interrupt_split_test.sv
`timescale 1ns/1ps
module isd_interrupt_split_test;
	localparam [63:0] MO = 64'hF380_00FF_FFFF_FFFF;
	localparam [63:0] MI = 64'hF380_0000_FFFF_FFFF;
	localparam [63:0] MS = 64'hF000_00FF_0000_00FF;
	reg clk = 0, reset = 1, load = 0, dir_in = 0, mf_tick = 0, slow = 0;
	reg [63:0] word3 = 64'h0;
	reg [7:0] word1 = 8'h00;
	reg [2:0] microframe = 3'h0;
	reg [4:0] bus_frame = 5'h00, fr;
	wire issue_req, issue_complete, result_valid, done_pulse;
	wire [2:0] result_code;
	wire [63:0] w3;
	logic [63:0] exp_q[$], msk_q[$], e, m;
	integer n_fail = 0, n_tests = 0, n_iss = 0, n_cs = 0, seed = 54166, i, n0;
	isd_interrupt_split i_isd_interrupt_split (.clk(clk), .reset(reset), .load(load),
		.load_word_three(word3), .load_word_one(word1), .load_valid(1'b1), .dir_in(dir_in),
		.microframe(microframe), .bus_frame(bus_frame), .mf_tick(mf_tick),
		.issue_req(issue_req), .issue_complete(issue_complete), .result_valid(result_valid),
		.result_code(result_code), .descriptor_word_three(w3), .done_pulse(done_pulse));
	isd_dev_model i_isd_dev_model (.clk(clk), .reset(reset), .issue_req(issue_req),
		.slow(slow), .result_valid(result_valid), .result_code(result_code));
	initial forever #12.5 clk = ~clk;
	task give_verdict;
		begin
			if (n_fail == 0 && n_tests > 0)
				$display("[ PASS ]");
			else
				$display("[ FAIL ]");
			$finish;
		end
	endtask
	task check(input [63:0] ex, input [63:0] got);
		begin
			n_tests = n_tests + 1;
			if (got !== ex) begin
				n_fail = n_fail + 1;
				$display("mismatch t=%0t exp=%h got=%h", $time, ex, got);
			end
		end
	endtask
	// each retired descriptor is compared with the oldest note; issued splits are counted
	always @(posedge clk) begin
		if (issue_req === 1'b1)
			n_iss = n_iss + 1;
		if (issue_req === 1'b1 && issue_complete === 1'b1)
			n_cs = n_cs + 1;
		if (done_pulse === 1'b1) begin
			if (exp_q.size() == 0) begin
				n_fail = n_fail + 1;
				$display("mismatch t=%0t exp=%h got=%h", $time, 64'h0, w3);
			end else begin
				e = exp_q.pop_front();
				m = msk_q.pop_front();
				check(e, w3 & m);
			end
		end
	end
	// load a descriptor and visit it every cycle; a missed frame must never issue
	task run(input [63:0] w, input din, input sl, input miss, input [2:0] c1,
		input [2:0] c2, input [63:0] ex, input [63:0] mk);
		begin
			i_isd_dev_model.codes = '{c1, c2};
			if (!miss) begin
				exp_q.push_back(ex);
				msk_q.push_back(mk);
			end
			n0 = n_iss;
			fr = 5'($random(seed));
			@(posedge clk);
			load <= 1'b1;
			word3 <= w;
			word1 <= {fr, 3'h0};
			dir_in <= din;
			slow <= sl;
			bus_frame <= fr ^ {4'h0, miss};
			@(posedge clk);
			load <= 1'b0;
			mf_tick <= 1'b1;
			for (i = 0; i < 60; i = i + 1) begin
				@(posedge clk) microframe <= microframe + 3'h1;
				@(negedge clk);
				if (done_pulse === 1'b1)
					break;
			end
			@(posedge clk) mf_tick <= 1'b0;
			if (miss)
				check(n0, n_iss);
			else if (i == 60) begin
				n_fail = n_fail + 1;
				give_verdict;
			end
		end
	endtask
	initial begin
		repeat (10) @(posedge clk);
		reset <= 1'b0;
		run(64'h8180_0000_0000_0001, 0, 0, 0, 3'h0, 3'h0, 64'h0380_0000_0000_0000, MO);
		run(64'h8180_0000_0000_0001, 0, 1, 0, 3'h3, 3'h0, 64'h0300_0000_0000_0000, MO);
		run(64'h8000_0000_0000_0001, 0, 0, 0, 3'h3, 3'h0, 64'h5000_0000_0000_0100, MO);
		run(64'h8180_0000_0000_0001, 0, 0, 0, 3'h2, 3'h0, 64'h4000_0000_0000_0000, MS);
		run(64'h8000_0004_0000_0001, 1, 0, 0, 3'h4, 3'h0, 64'h6000_0000_0000_0200, MI);
		run(64'h8380_0004_0000_00F1, 1, 1, 0, 3'h0, 3'h0, 64'h0180_0000_0000_0000, MI);
		check(1, n_cs);
		run(64'h8000_0000_0000_0001, 0, 0, 0, 3'h5, 3'h0, 64'h4000_0000_0000_0400, MO);
		run(64'h8180_0000_0000_0001, 0, 0, 1, 3'h0, 3'h0, 64'h0, 64'h0);
		give_verdict;
	end
endmodule // isd_interrupt_split_test
